// ### hdl/dpmbx_host.v
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`include "dpmbx_map.vh"
module dpmbx_host #(
   parameter AW = 15,
   parameter DW = 8,
   parameter RIGHT_PORT = 1'b0,
   parameter ACCESS_CYC = (`DPMBX_ACCESS_NS + `DPMBX_CLK_NS - 1) / `DPMBX_CLK_NS,
   parameter SETTLE_CYC = (`DPMBX_SETTLE_NS + `DPMBX_CLK_NS - 1) / `DPMBX_CLK_NS,
   parameter GAP_CYC = (`DPMBX_GAP_NS + `DPMBX_CLK_NS - 1) / `DPMBX_CLK_NS
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg mem_select_n,
   output reg token_latch_select_n,
   output reg rw_n,
   output reg oe_n,
   output reg [AW-1:0] addr,
   input wire [DW-1:0] data_in,
   output reg [DW-1:0] data_out,
   output reg data_oe,
   input wire mbx_flag_n,
   input wire busy_flag_n,
   output reg busy_flag_out_n,
   output reg busy_flag_oe,
   output reg role_master
);
   // ==================================================
   // Pin synchronisers
   wire [DW+1:0] pins_s;
   wire [DW-1:0] data_s;
   wire mbx_s_n;
   wire busy_s_n;
   dpmbx_sync #(.W(DW + 2)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({mbx_flag_n, busy_flag_n, data_in}),
      .q(pins_s)
   );
   assign data_s = pins_s[DW-1:0];
   assign busy_s_n = pins_s[DW];
   assign mbx_s_n = pins_s[DW+1];
   // ==================================================
   // Registers
   reg [31:0] ctrl_r;
   reg [AW-1:0] addr_r;
   reg [DW-1:0] wdata_r;
   reg [DW-1:0] rdata_r;
   reg done_r;
   reg got_r;
   reg [7:0] awaddr_r;
   reg aw_have_r;
   reg [31:0] wd_r;
   reg [3:0] ws_r;
   reg w_have_r;
   wire [1:0] op = ctrl_r[`DPMBX_CTRL_OP_MSB:`DPMBX_CTRL_OP_LSB];
   wire slave_mode = ctrl_r[`DPMBX_CTRL_SLAVE];
   localparam S_IDLE = 3'h0;
   localparam S_SETUP = 3'h1;
   localparam S_STROBE = 3'h2;
   localparam S_GAP = 3'h3;
   localparam S_CHECK = 3'h4;
   localparam S_SETTLE = 3'h5;
   reg [2:0] state_r;
   reg [7:0] cnt_r;
   reg readback_r;
   wire running = (state_r != S_IDLE);
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] st;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (st[i]) begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction
   function [7:0] cyc8;
      input integer n;
      begin
         cyc8 = (n < 1) ? 8'h01 : n[7:0];
      end
   endfunction
   // ==================================================
   // AXI4-Lite write channel: address and data in either order
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready = !w_have_r && !s_axi_bvalid;
   wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   // Decoded from the word being written, so a GO write runs its own op and mode, not the previous ones
   wire [31:0] ctrl_in = merge(ctrl_r, wd_r, ws_r) & 32'h0000_007e;
   wire [1:0] op_in = ctrl_in[`DPMBX_CTRL_OP_MSB:`DPMBX_CTRL_OP_LSB];
   wire tok_in = (op_in == `DPMBX_OP_TAKE) || (op_in == `DPMBX_OP_FREE);
   wire [31:0] addr_in = merge({{(32-AW){1'b0}}, addr_r}, wd_r, ws_r);
   wire [31:0] wdata_in = merge({{(32-DW){1'b0}}, wdata_r}, wd_r, ws_r);
   wire start = wr_go && (awaddr_r == `DPMBX_REG_CTRL) && ws_r[0] && wd_r[`DPMBX_CTRL_GO] && !running;
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 8'h00;
         wd_r <= 32'h0000_0000;
         ws_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         ctrl_r <= `DPMBX_RESET_CTRL;
         addr_r <= {AW{1'b0}};
         wdata_r <= {DW{1'b0}};
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wd_r <= s_axi_wdata;
            ws_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (awaddr_r)
               `DPMBX_REG_CTRL: begin
                  if (!running) begin
                     ctrl_r <= ctrl_in;
                  end
               end
               `DPMBX_REG_ADDR: addr_r <= addr_in[AW-1:0];
               `DPMBX_REG_WDATA: wdata_r <= wdata_in[DW-1:0];
               `DPMBX_REG_STAT: s_axi_bresp <= 2'h0;
               `DPMBX_REG_RDATA: s_axi_bresp <= 2'h0;
               default: s_axi_bresp <= 2'h2;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // ==================================================
   // AXI4-Lite read channel
   assign s_axi_arready = !s_axi_rvalid;
   // The mailbox flag is only reported here and never routed to an interrupt
   wire [31:0] stat_w = {27'h0, !busy_s_n, !mbx_s_n, got_r, done_r, running};
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         case (s_axi_araddr)
            `DPMBX_REG_CTRL: s_axi_rdata <= ctrl_r;
            `DPMBX_REG_ADDR: s_axi_rdata <= {{(32-AW){1'b0}}, addr_r};
            `DPMBX_REG_WDATA: s_axi_rdata <= {{(32-DW){1'b0}}, wdata_r};
            `DPMBX_REG_STAT: s_axi_rdata <= stat_w;
            `DPMBX_REG_RDATA: s_axi_rdata <= {{(32-DW){1'b0}}, rdata_r};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // ==================================================
   // Port sequencer
   // The own mailbox is the word the partner writes to raise our flag
   wire [AW-1:0] own_mbx = RIGHT_PORT ? `DPMBX_MBX_RIGHT : `DPMBX_MBX_LEFT;
   wire is_token = (op == `DPMBX_OP_TAKE) || (op == `DPMBX_OP_FREE);
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= S_IDLE;
         cnt_r <= 8'h00;
         readback_r <= 1'b0;
         mem_select_n <= 1'b1;
         token_latch_select_n <= 1'b1;
         rw_n <= 1'b1;
         oe_n <= 1'b1;
         addr <= {AW{1'b0}};
         data_out <= {DW{1'b0}};
         data_oe <= 1'b0;
         rdata_r <= {DW{1'b0}};
         done_r <= 1'b0;
         got_r <= 1'b0;
         busy_flag_out_n <= 1'b1;
         busy_flag_oe <= 1'b0;
         role_master <= 1'b1;
      end else begin
         role_master <= !slave_mode;
         busy_flag_oe <= 1'b0;
         if (start) begin
            done_r <= 1'b0;
            readback_r <= 1'b0;
            // Upper bits are ignored by the latches; drive zero anyway
            addr <= tok_in ? {{(AW-3){1'b0}}, ctrl_in[`DPMBX_CTRL_TOKEN_MSB:`DPMBX_CTRL_TOKEN_LSB]} : addr_r;
            data_out <= (op_in == `DPMBX_OP_TAKE) ? {DW{1'b0}} :
                        (op_in == `DPMBX_OP_FREE) ? {{(DW-1){1'b0}}, 1'b1} : wdata_r;
            // Slave writes wait for the busy line to settle first
            state_r <= (ctrl_in[`DPMBX_CTRL_SLAVE] && op_in != `DPMBX_OP_RD) ? S_SETTLE : S_SETUP;
            cnt_r <= cyc8(SETTLE_CYC);
         end else begin
            case (state_r)
               S_IDLE: cnt_r <= 8'h00;
               S_SETTLE: begin
                  if (cnt_r > 8'h01) begin
                     cnt_r <= cnt_r - 8'h01;
                  end else begin
                     state_r <= S_SETUP;
                  end
               end
               S_SETUP: begin
                  // Memory select stays high during token access
                  mem_select_n <= is_token;
                  token_latch_select_n <= !is_token;
                  if (op == `DPMBX_OP_RD || readback_r) begin
                     oe_n <= 1'b0;
                  end else begin
                     rw_n <= 1'b0;
                     data_oe <= 1'b1;
                  end
                  // Reads hold the strobe two cycles longer so the data crosses the pin synchroniser
                  cnt_r <= cyc8(ACCESS_CYC) + ((op == `DPMBX_OP_RD || readback_r) ? 8'h02 : 8'h00);
                  state_r <= S_STROBE;
               end
               S_STROBE: begin
                  if (cnt_r > 8'h01) begin
                     cnt_r <= cnt_r - 8'h01;
                  end else begin
                     // Read data sampled at the end, while still enabled
                     if (!oe_n) begin
                        rdata_r <= data_s;
                     end
                     mem_select_n <= 1'b1;
                     token_latch_select_n <= 1'b1;
                     rw_n <= 1'b1;
                     oe_n <= 1'b1;
                     data_oe <= 1'b0;
                     cnt_r <= cyc8(GAP_CYC);
                     state_r <= S_GAP;
                  end
               end
               S_GAP: begin
                  // Select deasserted for the idle gap before a TAKE reads back or the op ends
                  if (cnt_r > 8'h01) begin
                     cnt_r <= cnt_r - 8'h01;
                  end else if (op == `DPMBX_OP_TAKE && !readback_r) begin
                     readback_r <= 1'b1;
                     state_r <= S_SETUP;
                  end else if (op == `DPMBX_OP_TAKE) begin
                     state_r <= S_CHECK;
                  end else begin
                     done_r <= 1'b1;
                     state_r <= S_IDLE;
                  end
               end
               S_CHECK: begin
                  // Zero on bit 0 means owned; one means software polls again
                  got_r <= !rdata_r[0];
                  done_r <= 1'b1;
                  state_r <= S_IDLE;
               end
               default: state_r <= S_IDLE;
            endcase
         end
      end
   end
endmodule

// ### common/dpmbx_map.vh
`ifndef DPMBX_MAP_VH
`define DPMBX_MAP_VH
// ==================================================
// Register offsets of the controller (byte addresses)
`define DPMBX_REG_CTRL 8'h00
`define DPMBX_REG_ADDR 8'h04
`define DPMBX_REG_WDATA 8'h08
`define DPMBX_REG_STAT 8'h0c
`define DPMBX_REG_RDATA 8'h10
// ==================================================
// Control register fields
`define DPMBX_CTRL_GO 0
`define DPMBX_CTRL_OP_LSB 1
`define DPMBX_CTRL_OP_MSB 2
`define DPMBX_CTRL_SLAVE 3
`define DPMBX_CTRL_TOKEN_LSB 4
`define DPMBX_CTRL_TOKEN_MSB 6
// Operations
`define DPMBX_OP_RD 2'h0
`define DPMBX_OP_WR 2'h1
`define DPMBX_OP_TAKE 2'h2
`define DPMBX_OP_FREE 2'h3
// ==================================================
// Status register fields
`define DPMBX_STAT_BUSY 0
`define DPMBX_STAT_DONE 1
`define DPMBX_STAT_GOT 2
`define DPMBX_STAT_MBX 3
`define DPMBX_STAT_CONT 4
// ==================================================
// Mailbox words
`define DPMBX_MBX_RIGHT 15'h7fff
`define DPMBX_MBX_LEFT 15'h7ffe
// ==================================================
// Timing in ns at a 20 ns clock period
`define DPMBX_CLK_NS 20
`define DPMBX_ACCESS_NS 20
`define DPMBX_SETTLE_NS 20
`define DPMBX_GAP_NS 20
`define DPMBX_RESET_CTRL 32'h0000_0000
`endif

// ### hdl/dpmbx_sync.v
// ==================================================
// Two flip-flop synchroniser for pins from the device
module dpmbx_sync #(
   parameter W = 1
) (
   input wire aclk,
   input wire aresetn,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= {W{1'b1}};
         s2_r <= {W{1'b1}};
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule

// ### tb/dpmbx_host_chk.sv
module dpmbx_host_chk #(
   parameter DW = 8
) (
   input logic aclk,
   input logic aresetn,
   input logic mem_select_n,
   input logic token_latch_select_n,
   input logic rw_n,
   input logic oe_n,
   input logic [DW-1:0] data_out,
   input logic data_oe,
   input logic busy_flag_out_n,
   input logic busy_flag_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Pin protocol
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence tok_take;
      !token_latch_select_n && !rw_n && !data_out[0];
   endsequence
   sequence tok_read;
      !token_latch_select_n && !oe_n && rw_n;
   endsequence
   sequence rd_strobe;
      !oe_n [*2] ##1 oe_n;
   endsequence
   sel_excl_a:
      assert property (!token_latch_select_n |-> mem_select_n) else $error("both selects low");
   take_back_a:
      assert property (tok_take ##1 token_latch_select_n |-> ##[1:8] tok_read) else $error("no read back");
   tok_pulse_a:
      assert property ($fell(token_latch_select_n) && !rw_n |=> token_latch_select_n) else $error("no token gap");
   tok_gap_a:
      assert property ($rose(token_latch_select_n) |=> token_latch_select_n) else $error("token gap too short");
   mem_pulse_a:
      assert property ($fell(mem_select_n) && !rw_n |=> mem_select_n) else $error("memory strobe length");
   rd_hold_a:
      assert property ($fell(oe_n) |=> rd_strobe) else $error("read strobe length");
   strobe_excl_a:
      assert property (rw_n || oe_n) else $error("write and read strobes together");
   no_fight_a:
      assert property (!oe_n |-> !data_oe) else $error("data driven during read");
   wr_drive_a:
      assert property (!rw_n |-> data_oe) else $error("write without data");
   busy_quiet_a:
      assert property (busy_flag_out_n && !busy_flag_oe) else $error("busy pin driven");
endmodule
bind dpmbx_host dpmbx_host_chk #(.DW(DW)) u_chk (.aclk(aclk), .aresetn(aresetn), .mem_select_n(mem_select_n),
   .token_latch_select_n(token_latch_select_n), .rw_n(rw_n), .oe_n(oe_n), .data_out(data_out),
   .data_oe(data_oe), .busy_flag_out_n(busy_flag_out_n), .busy_flag_oe(busy_flag_oe));

// ### tb/dpmbx_dev_model.sv
`include "dpmbx_map.vh"
module dpmbx_dev_model (
   input logic aclk,
   input logic mem_select_n,
   input logic token_latch_select_n,
   input logic rw_n,
   input logic oe_n,
   input logic [14:0] addr,
   input logic [7:0] data_out,
   output logic [7:0] data_in,
   output logic mbx_flag_n,
   output logic busy_flag_n,
   input logic far_mbx_wr,
   input logic far_tok_wr,
   input logic [2:0] far_idx,
   input logic [7:0] far_data,
   input logic host_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Device state, host is the left port
   logic [7:0] mem [logic [14:0]];
   logic req [2][8] = '{default: 1'b0};
   logic own [2][8] = '{default: 1'b0};
   logic [7:0] rd_r = 8'h00;
   int hold = 0;
   logic far_mbx_n = 1'b1;
   assign data_in = rd_r;
   // Contention is always granted to the far port while host_busy is high
   assign busy_flag_n = !host_busy;
   initial mbx_flag_n = 1'b1;
   task automatic tok_wr(input int s, input int i, input logic b);
      req[s][i] = !b;
      if (b) own[s][i] = 1'b0;
      if (!own[0][i] && !own[1][i]) begin
         own[0][i] = req[0][i];
         own[1][i] = req[1][i] && !req[0][i];
      end
   endtask
   // Latched when the read starts so a far write cannot disturb it
   always @(negedge oe_n) begin
      #1;
      if (!token_latch_select_n && mem_select_n) rd_r = {8{!own[0][addr[2:0]]}};
      else if (!mem_select_n) rd_r = mem.exists(addr) ? mem[addr] : 8'h00;
   end
   always @(posedge aclk) begin
      if (far_mbx_wr) begin
         mem[`DPMBX_MBX_LEFT] = far_data;
         mbx_flag_n <= 1'b0;
      end
      if (far_tok_wr) tok_wr(1, far_idx, far_data[0]);
      if (!token_latch_select_n && !rw_n) tok_wr(0, addr[2:0], data_out[0]);
      if (!mem_select_n && !rw_n) mem[addr] = data_out;
      if (!mem_select_n && !rw_n && addr == `DPMBX_MBX_RIGHT && !host_busy) far_mbx_n <= 1'b0;
      if (!mem_select_n && !oe_n && addr == `DPMBX_MBX_LEFT && !host_busy) mbx_flag_n <= 1'b1;
      if (!oe_n) hold <= 3;
      else if (hold > 0) hold <= hold - 1;
      else rd_r <= ~rd_r;
   end
endmodule

// ### tb/testbench.sv
`include "dpmbx_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic mem_select_n, token_latch_select_n, rw_n, oe_n, data_oe, mbx_flag_n, busy_flag_n, role_master;
   logic [14:0] addr;
   logic [7:0] data_in, data_out, far_data = 8'h00;
   logic [2:0] far_idx = 3'h0;
   logic far_mbx_wr = 1'b0, far_tok_wr = 1'b0, host_busy = 1'b0;
   logic [31:0] v;
   int n_mismatch = 0, check_count = 0;
   typedef struct {logic [1:0] o; logic [2:0] t; logic [14:0] a; logic [7:0] d; logic [7:0] rg, m, e;} dpmbx_row_t;
   dpmbx_row_t rows [6] = '{'{`DPMBX_OP_WR, 0, 15'h7fff, 8'h5a, `DPMBX_REG_STAT, 8'h08, 8'h00},
      '{`DPMBX_OP_RD, 0, 15'h7fff, 8'h00, `DPMBX_REG_RDATA, 8'hff, 8'h5a},
      '{`DPMBX_OP_WR, 0, 15'h1234, 8'hc3, `DPMBX_REG_STAT, 8'h08, 8'h00},
      '{`DPMBX_OP_RD, 0, 15'h1234, 8'h00, `DPMBX_REG_RDATA, 8'hff, 8'hc3},
      '{`DPMBX_OP_TAKE, 3, 15'h0000, 8'h00, `DPMBX_REG_STAT, 8'h04, 8'h04},
      '{`DPMBX_OP_TAKE, 7, 15'h7ff8, 8'h00, `DPMBX_REG_STAT, 8'h04, 8'h04}};
   dpmbx_host dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_select_n,
      .token_latch_select_n, .rw_n, .oe_n, .addr, .data_in, .data_out, .data_oe, .mbx_flag_n, .busy_flag_n,
      .busy_flag_out_n(), .busy_flag_oe(), .role_master);
   dpmbx_dev_model dev (.aclk, .mem_select_n, .token_latch_select_n, .rw_n, .oe_n, .addr, .data_out, .data_in,
      .mbx_flag_n, .busy_flag_n, .far_mbx_wr, .far_tok_wr, .far_idx, .far_data, .host_busy);
   initial forever #10 aclk = ~aclk;
   // ==========
   // Bus and comparison helpers
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      // Ready stays high between transfers so back-to-back calls never toggle it in one step
      rs = s_axi_bresp;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   task automatic op(input logic [1:0] o, input logic [2:0] t, input logic sl, input logic [14:0] a,
      input logic [7:0] d);
      axi_wr(`DPMBX_REG_ADDR, {17'h0, a}, r);
      axi_wr(`DPMBX_REG_WDATA, {24'h0, d}, r);
      axi_wr(`DPMBX_REG_CTRL, {25'h0, t, sl, o, 1'b1}, r);
      do axi_rd(`DPMBX_REG_STAT, v, r); while (v[0] !== 1'b0 || v[1] !== 1'b1);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      axi_rd(a, v, r);
      chk(v & m, e);
   endtask
   task automatic far(input logic mw, input logic tw, input logic [2:0] i, input logic [7:0] d);
      far_mbx_wr <= mw;
      far_tok_wr <= tw;
      far_idx <= i;
      far_data <= d;
      @(posedge aclk);
      far_mbx_wr <= 1'b0;
      far_tok_wr <= 1'b0;
      // Let the flags cross the pin synchroniser before status is read
      repeat (2) @(posedge aclk);
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk({mem_select_n, token_latch_select_n, role_master}, 3'b111);
      reg_chk(`DPMBX_REG_STAT, 32'h1f, 32'h0);
      reg_chk(`DPMBX_REG_CTRL, 32'hffffffff, `DPMBX_RESET_CTRL);
      axi_rd(8'h14, v, r);
      chk(v, 32'h0);
      chk(r, 2'b10);
      axi_wr(8'h14, 32'h1, r);
      chk(r, 2'b10);
      host_busy <= 1'b1;
      op(`DPMBX_OP_WR, 0, 1'b0, `DPMBX_MBX_RIGHT, 8'ha5);
      chk(dev.far_mbx_n, 1'b1);
      host_busy <= 1'b0;
      foreach (rows[k]) begin
         op(rows[k].o, rows[k].t, 1'b0, rows[k].a, rows[k].d);
         reg_chk(rows[k].rg, rows[k].m, rows[k].e);
      end
      chk(dev.far_mbx_n, 1'b0);
      far(1'b1, 1'b0, 3'h0, 8'h3c);
      reg_chk(`DPMBX_REG_STAT, 32'h08, 32'h08);
      host_busy <= 1'b1;
      op(`DPMBX_OP_RD, 0, 1'b0, `DPMBX_MBX_LEFT, 8'h00);
      reg_chk(`DPMBX_REG_STAT, 32'h18, 32'h18);
      host_busy <= 1'b0;
      op(`DPMBX_OP_RD, 0, 1'b0, `DPMBX_MBX_LEFT, 8'h00);
      reg_chk(`DPMBX_REG_RDATA, 32'hff, 32'h3c);
      reg_chk(`DPMBX_REG_STAT, 32'h18, 32'h00);
      far(1'b0, 1'b1, 3'h5, 8'h00);
      op(`DPMBX_OP_TAKE, 5, 1'b0, 15'h0005, 8'h00);
      reg_chk(`DPMBX_REG_STAT, 32'h04, 32'h00);
      far(1'b0, 1'b1, 3'h5, 8'h01);
      op(`DPMBX_OP_TAKE, 5, 1'b0, 15'h0005, 8'h00);
      reg_chk(`DPMBX_REG_STAT, 32'h04, 32'h04);
      op(`DPMBX_OP_FREE, 5, 1'b0, 15'h0005, 8'h00);
      far(1'b0, 1'b1, 3'h5, 8'h00);
      op(`DPMBX_OP_TAKE, 5, 1'b0, 15'h0005, 8'h00);
      reg_chk(`DPMBX_REG_STAT, 32'h04, 32'h00);
      op(`DPMBX_OP_WR, 0, 1'b1, 15'h0010, 8'h77);
      chk(role_master, 1'b0);
      op(`DPMBX_OP_RD, 0, 1'b1, 15'h0010, 8'h00);
      reg_chk(`DPMBX_REG_RDATA, 32'hff, 32'h77);
      op(`DPMBX_OP_RD, 0, 1'b0, 15'h0010, 8'h00);
      chk(role_master, 1'b1);
      tally_and_finish();
   end
endmodule
